// ==== include/timer_pkg.sv ====
// package for the dual timer and external interrupt control block
// assumes one cpu clock and a byte-wide register port from the cpu core
package timer_pkg;

  // register addresses
  localparam logic [7:0] TIMER_IRQ_CONTROL_ADDR  = 8'h88;
  localparam logic [7:0] TIMER_MODE_REG_ADDR     = 8'h89;
  localparam logic [7:0] TL_A_ADDR  = 8'h8a;
  localparam logic [7:0] TL_B_ADDR  = 8'h8b;
  localparam logic [7:0] TH_A_ADDR  = 8'h8c;
  localparam logic [7:0] TH_B_ADDR  = 8'h8d;
  localparam logic [7:0] TIMER_RATE_CONTROL_ADDR = 8'h8e;

  // values after reset
  localparam logic [7:0] IRQ_CONTROL_RESET  = 8'h00;
  localparam logic [7:0] MODE_REG_RESET     = 8'h00;
  localparam logic [7:0] RATE_CONTROL_RESET = 8'h01;
  localparam logic [7:0] COUNT_RESET        = 8'h00;

  // cpu clocks per timer increment
  localparam int FAST_DIV = 4;
  localparam int SLOW_DIV = 12;

  // stretched external data move length
  localparam logic [3:0] STRETCH_BASE  = 4'h2;
  localparam logic [3:0] STRETCH_RESET = 4'h3;

  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD8,
    MODE_SPLIT
  } mode_e;

  typedef struct packed {
    logic  gate;
    logic  counter_sel;
    mode_e mode;
  } timer_ctl_s;

  typedef struct packed {
    timer_ctl_s b;
    timer_ctl_s a;
  } timer_mode_reg_s;

  typedef struct packed {
    logic timer_b_overflow_flag;
    logic timer_b_run;
    logic timer_a_overflow_flag;
    logic timer_a_run;
    logic ext_irq_b_detect;
    logic ext_irq_b_type;
    logic ext_irq_a_detect;
    logic ext_irq_a_type;
  } timer_irq_control_s;

  typedef struct packed {
    logic [1:0] reserved;
    logic       timer_c_rate_select;
    logic       timer_b_rate_select;
    logic       timer_a_rate_select;
    logic [2:0] xdata_stretch_bits;
  } timer_rate_control_s;

  typedef struct packed {
    logic       ovf;
    logic [7:0] hi;
    logic [7:0] lo;
  } count_s;

endpackage

// ==== hdl/dual_timer_ext_irq_ctrl.sv ====
// two timer/counters with their control and the two external interrupt detectors
// assumes pins synchronous to CLOCK_I and a single-cycle register write strobe
//
// Behaviour
// - overflow flag sets on wrap, clears on vectoring
// - run bit zero stops and holds count, except timer b while timer a is in mode 3
// - edge mode: falling pin edge sets detect flag
// - level mode: detect follows low pin, writes ignored
// - type bit one edge, zero level
// - mode 0 is 13-bit: low five, high eight
// - gate one counts only while irq pin high
// - 13-bit wrap sets flag, one-cycle output pulse
// - mode 1 full 16-bit counter wrapping
// - mode 2 reloads low byte from high
// - mode 3 low byte uses timer a controls
// - mode 3 high byte uses timer b run/flag
// - timer b in mode 3 holds its count
// - timer a split: b runs unless mode 3
// - rate bit picks divide by four or twelve
// - third timer rate bit exported only
// - data move cycles are two plus stretch
// - counter function counts count pin falling edges
// - mode bits decode to four modes
// - source bit zero clock, one count pin
// - timer b gate uses its pin and run
module dual_timer_ext_irq_ctrl #(
  parameter int FAST_DIV = timer_pkg::FAST_DIV,
  parameter int SLOW_DIV = timer_pkg::SLOW_DIV
) (
  input  wire logic       CLOCK_I,
  input  wire logic       RESET_N_I,
  input  wire logic [7:0] SFR_ADDR_I,
  input  wire logic       SFR_WR_I,
  input  wire logic [7:0] SFR_WDATA_I,
  input  wire logic       TIMER_A_VECTOR_I,
  input  wire logic       TIMER_B_VECTOR_I,
  input  wire logic       EXT_IRQ_A_VECTOR_I,
  input  wire logic       EXT_IRQ_B_VECTOR_I,
  input  wire logic       EXT_IRQ_A_PIN_N_I,
  input  wire logic       EXT_IRQ_B_PIN_N_I,
  input  wire logic       TIMER_A_COUNT_PIN_I,
  input  wire logic       TIMER_B_COUNT_PIN_I,
  output logic      [7:0] SFR_RDATA_O,
  output logic            TIMER_A_OVERFLOW_FLAG_O,
  output logic            TIMER_B_OVERFLOW_FLAG_O,
  output logic            EXT_IRQ_A_DETECT_O,
  output logic            EXT_IRQ_B_DETECT_O,
  output logic            TIMER_A_OVERFLOW_PULSE_O,
  output logic            TIMER_B_OVERFLOW_PULSE_O,
  output logic            TIMER_C_RATE_SELECT_O,
  output logic      [3:0] XDATA_STRETCH_CYCLES_O
);

  localparam int PW = $clog2(SLOW_DIV);

  if (FAST_DIV < 1 || SLOW_DIV < 2 || (SLOW_DIV % FAST_DIV) != 0) begin : g_bad_div
    $error("divide ratios must be positive and the slow one a multiple of the fast one");
  end

  timer_pkg::timer_mode_reg_s     mode_reg;
  timer_pkg::timer_rate_control_s rate_ctl;
  timer_pkg::timer_irq_control_s  irq_ctl_view;
  timer_pkg::count_s step_val [2];
  logic [7:0]        lo [2];
  logic [7:0]        hi [2];
  logic [1:0]        tf;
  logic [1:0]        tr;
  logic [1:0]        ie;
  logic [1:0]        it;
  logic [1:0]        irq_pin_prev;
  logic [1:0]        count_pin_prev;
  logic [PW-1:0]     presc;
  logic              tick_fast;
  logic              tick_slow;
  logic              a_split;
  logic [1:0]        irq_pin_n;
  logic [1:0]        count_pin;
  logic [1:0]        count_fall;
  logic [1:0]        irq_fall;
  logic [1:0]        rate;
  logic [1:0]        vec_tf;
  logic [1:0]        vec_ie;
  logic [1:0]        src;
  logic [1:0]        gate_ok;
  logic [1:0]        run;
  logic [1:0]        inc;
  logic [1:0]        ovf;
  logic [1:0]        set_tf;
  logic [1:0]        wr_lo;
  logic [1:0]        wr_hi;
  logic              wr_irq_ctl;
  logic              inc_ah;
  logic              ovf_ah;
  logic [7:0]        wdata_irq_ctl;

  function automatic logic hit(input logic [7:0] addr);
    return SFR_WR_I && (SFR_ADDR_I == addr);
  endfunction

  // one increment of a timer in the given mode
  function automatic timer_pkg::count_s step(input timer_pkg::mode_e m,
                                              input logic [7:0] l,
                                              input logic [7:0] h);
    logic [13:0]        c13;
    logic [16:0]        c16;
    logic [8:0]         c8;
    timer_pkg::count_s  r;
    c13   = {1'b0, h, l[4:0]} + 14'h0001;
    c16   = {1'b0, h, l} + 17'h00001;
    c8    = {1'b0, l} + 9'h001;
    r.ovf = 1'b0;
    r.hi  = h;
    r.lo  = l;
    case (m)
      timer_pkg::MODE_13BIT: begin
        r.ovf = c13[13];
        r.hi  = c13[12:5];
        r.lo  = {l[7:5], c13[4:0]};
      end
      timer_pkg::MODE_16BIT: begin
        r = {c16[16], c16[15:8], c16[7:0]};
      end
      timer_pkg::MODE_RELOAD8: begin
        r.ovf = c8[8];
        r.lo  = c8[8] ? h : c8[7:0];
      end
      default: begin
        r.ovf = c8[8];
        r.lo  = c8[7:0];
      end
    endcase
    return r;
  endfunction

  // shared cpu clock prescaler
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      presc <= '0;
    end else if (tick_slow) begin
      presc <= '0;
    end else begin
      presc <= presc + PW'(1);
    end
  end

  always_comb begin
    tick_slow  = (presc == PW'(SLOW_DIV - 1));
    tick_fast  = ((32'(presc) % FAST_DIV) == (FAST_DIV - 1));
    a_split    = (mode_reg.a.mode == timer_pkg::MODE_SPLIT);
    irq_pin_n  = {EXT_IRQ_B_PIN_N_I, EXT_IRQ_A_PIN_N_I};
    count_pin  = {TIMER_B_COUNT_PIN_I, TIMER_A_COUNT_PIN_I};
    count_fall = count_pin_prev & ~count_pin;
    irq_fall   = irq_pin_prev & ~irq_pin_n;
    rate       = {rate_ctl.timer_b_rate_select, rate_ctl.timer_a_rate_select};
    vec_tf     = {TIMER_B_VECTOR_I, TIMER_A_VECTOR_I};
    vec_ie     = {EXT_IRQ_B_VECTOR_I, EXT_IRQ_A_VECTOR_I};
    wr_lo      = {hit(timer_pkg::TL_B_ADDR), hit(timer_pkg::TL_A_ADDR)};
    wr_hi      = {hit(timer_pkg::TH_B_ADDR), hit(timer_pkg::TH_A_ADDR)};
    wr_irq_ctl    = hit(timer_pkg::TIMER_IRQ_CONTROL_ADDR);
    wdata_irq_ctl = SFR_WDATA_I;
    src[0]     = mode_reg.a.counter_sel ? count_fall[0] : (rate[0] ? tick_fast : tick_slow);
    src[1]     = mode_reg.b.counter_sel ? count_fall[1] : (rate[1] ? tick_fast : tick_slow);
    gate_ok[0] = !mode_reg.a.gate || irq_pin_n[0];
    gate_ok[1] = !mode_reg.b.gate || irq_pin_n[1];
    run[0]     = tr[0];
    run[1]     = (a_split || tr[1]) && (mode_reg.b.mode != timer_pkg::MODE_SPLIT);
    inc        = run & gate_ok & src;
    step_val[0] = step(mode_reg.a.mode, lo[0], hi[0]);
    step_val[1] = step(mode_reg.b.mode, lo[1], hi[1]);
    ovf[0]     = inc[0] && step_val[0].ovf;
    ovf[1]     = inc[1] && step_val[1].ovf;
    inc_ah     = a_split && tr[1] && (rate[0] ? tick_fast : tick_slow);
    ovf_ah     = inc_ah && (hi[0] == 8'hff);
    set_tf[0]  = ovf[0];
    set_tf[1]  = a_split ? ovf_ah : ovf[1];
  end

  // count registers; a software write wins over an increment
  for (genvar i = 0; i < 2; i++) begin : g_count
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
        lo[i] <= timer_pkg::COUNT_RESET;
      end else if (wr_lo[i]) begin
        lo[i] <= SFR_WDATA_I;
      end else if (inc[i]) begin
        lo[i] <= step_val[i].lo;
      end
    end

    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
        hi[i] <= timer_pkg::COUNT_RESET;
      end else if (wr_hi[i]) begin
        hi[i] <= SFR_WDATA_I;
      end else if (i == 0 && a_split) begin
        if (inc_ah) begin
          hi[i] <= hi[i] + 8'h01;
        end
      end else if (inc[i]) begin
        hi[i] <= step_val[i].hi;
      end
    end

    // overflow flag: hardware set wins over vector or write clear
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
        tf[i] <= 1'b0;
      end else if (set_tf[i]) begin
        tf[i] <= 1'b1;
      end else if (vec_tf[i]) begin
        tf[i] <= 1'b0;
      end else if (wr_irq_ctl) begin
        tf[i] <= wdata_irq_ctl[5 + 2 * i];
      end
    end

    // external interrupt detect
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
        ie[i] <= 1'b0;
      end else if (!it[i]) begin
        ie[i] <= !irq_pin_n[i];
      end else if (irq_fall[i]) begin
        ie[i] <= 1'b1;
      end else if (vec_ie[i]) begin
        ie[i] <= 1'b0;
      end else if (wr_irq_ctl) begin
        ie[i] <= wdata_irq_ctl[1 + 2 * i];
      end
    end
  end

  // run and type bits
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tr <= 2'b00;
      it <= 2'b00;
    end else if (wr_irq_ctl) begin
      tr <= {wdata_irq_ctl[6], wdata_irq_ctl[4]};
      it <= {wdata_irq_ctl[2], wdata_irq_ctl[0]};
    end
  end

  // pin history for falling edge detection
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      irq_pin_prev   <= 2'b11;
      count_pin_prev <= 2'b00;
    end else begin
      irq_pin_prev   <= irq_pin_n;
      count_pin_prev <= count_pin;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      mode_reg <= timer_pkg::timer_mode_reg_s'(timer_pkg::MODE_REG_RESET);
    end else if (hit(timer_pkg::TIMER_MODE_REG_ADDR)) begin
      mode_reg <= timer_pkg::timer_mode_reg_s'(SFR_WDATA_I);
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rate_ctl               <= timer_pkg::timer_rate_control_s'(timer_pkg::RATE_CONTROL_RESET);
      XDATA_STRETCH_CYCLES_O <= timer_pkg::STRETCH_RESET;
    end else if (hit(timer_pkg::TIMER_RATE_CONTROL_ADDR)) begin
      rate_ctl               <= timer_pkg::timer_rate_control_s'({2'b00, SFR_WDATA_I[5:0]});
      XDATA_STRETCH_CYCLES_O <= timer_pkg::STRETCH_BASE + {1'b0, SFR_WDATA_I[2:0]};
    end
  end

  // overflow pulses; timer b pulse keeps feeding baud logic in split mode
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      TIMER_A_OVERFLOW_PULSE_O <= 1'b0;
      TIMER_B_OVERFLOW_PULSE_O <= 1'b0;
    end else begin
      TIMER_A_OVERFLOW_PULSE_O <= ovf[0];
      TIMER_B_OVERFLOW_PULSE_O <= ovf[1];
    end
  end

  always_comb begin
    irq_ctl_view = '{timer_b_overflow_flag: tf[1], timer_b_run: tr[1],
                  timer_a_overflow_flag: tf[0], timer_a_run: tr[0],
                  ext_irq_b_detect: ie[1], ext_irq_b_type: it[1],
                  ext_irq_a_detect: ie[0], ext_irq_a_type: it[0]};
  end

  // registered read mux; unmapped addresses read zero
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      SFR_RDATA_O <= 8'h00;
    end else begin
      case (SFR_ADDR_I)
        timer_pkg::TIMER_IRQ_CONTROL_ADDR: SFR_RDATA_O <= irq_ctl_view;
        timer_pkg::TIMER_MODE_REG_ADDR:    SFR_RDATA_O <= mode_reg;
        timer_pkg::TL_A_ADDR:  SFR_RDATA_O <= lo[0];
        timer_pkg::TL_B_ADDR:  SFR_RDATA_O <= lo[1];
        timer_pkg::TH_A_ADDR:  SFR_RDATA_O <= hi[0];
        timer_pkg::TH_B_ADDR:  SFR_RDATA_O <= hi[1];
        timer_pkg::TIMER_RATE_CONTROL_ADDR: SFR_RDATA_O <= rate_ctl;
        default:               SFR_RDATA_O <= 8'h00;
      endcase
    end
  end

  assign TIMER_A_OVERFLOW_FLAG_O = tf[0];
  assign TIMER_B_OVERFLOW_FLAG_O = tf[1];
  assign EXT_IRQ_A_DETECT_O      = ie[0];
  assign EXT_IRQ_B_DETECT_O      = ie[1];
  assign TIMER_C_RATE_SELECT_O   = rate_ctl.timer_c_rate_select;

endmodule // dual_timer_ext_irq_ctrl

// ==== tb/timer_checker_sva.sv ====
// concurrent checks on the timer block ports
// assumes one clock, async active-low reset, bound onto the top module
module timer_checker (
  input wire logic       CLOCK_I,
  input wire logic       RESET_N_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic       SFR_WR_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic       TIMER_A_VECTOR_I,
  input wire logic       EXT_IRQ_A_VECTOR_I,
  input wire logic       EXT_IRQ_A_PIN_N_I,
  input wire logic       TIMER_A_OVERFLOW_FLAG_O,
  input wire logic       EXT_IRQ_A_DETECT_O,
  input wire logic       TIMER_A_OVERFLOW_PULSE_O,
  input wire logic       TIMER_B_OVERFLOW_PULSE_O,
  input wire logic [3:0] XDATA_STRETCH_CYCLES_O
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       ctl_wr;
  logic       type_a;
  logic [7:0] wdata_q;
  assign ctl_wr = SFR_WR_I && (SFR_ADDR_I == timer_pkg::TIMER_IRQ_CONTROL_ADDR);
  // shadow of the irq a type bit
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) type_a <= 1'b0;
    else if (ctl_wr) type_a <= SFR_WDATA_I[0];
  end
  always_ff @(posedge CLOCK_I) begin
    wdata_q <= SFR_WDATA_I;
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence s_pulse_a_once;
    TIMER_A_OVERFLOW_PULSE_O ##1 !TIMER_A_OVERFLOW_PULSE_O;
  endsequence
  a_pulse_a_single: assert property ($rose(TIMER_A_OVERFLOW_PULSE_O) |-> s_pulse_a_once)
    else $error("pulse a longer than one cycle");
  a_pulse_b_single: assert property (TIMER_B_OVERFLOW_PULSE_O |=> !TIMER_B_OVERFLOW_PULSE_O)
    else $error("pulse b longer than one cycle");
  a_wrap_sets_flag: assert property (TIMER_A_OVERFLOW_PULSE_O |-> TIMER_A_OVERFLOW_FLAG_O)
    else $error("flag a not set with pulse");
  a_vector_clears_flag: assert property ((TIMER_A_VECTOR_I && !ctl_wr) |=>
    (!TIMER_A_OVERFLOW_FLAG_O || TIMER_A_OVERFLOW_PULSE_O)) else $error("flag a not cleared");
  a_level_follows_pin: assert property ((!type_a && !ctl_wr) |=>
    (EXT_IRQ_A_DETECT_O == !$past(EXT_IRQ_A_PIN_N_I))) else $error("level detect wrong");
  a_edge_sets_detect: assert property ((type_a && $fell(EXT_IRQ_A_PIN_N_I)) |=>
    EXT_IRQ_A_DETECT_O) else $error("edge detect missed");
  a_edge_vector_clear: assert property ((type_a && EXT_IRQ_A_VECTOR_I && !ctl_wr &&
    !$fell(EXT_IRQ_A_PIN_N_I)) |=> !EXT_IRQ_A_DETECT_O) else $error("detect not cleared");
  a_stretch_follows: assert property ((SFR_WR_I &&
    SFR_ADDR_I == timer_pkg::TIMER_RATE_CONTROL_ADDR) |=>
    (XDATA_STRETCH_CYCLES_O == 4'h2 + {1'b0, wdata_q[2:0]})) else $error("stretch wrong");
endmodule // timer_checker

bind dual_timer_ext_irq_ctrl timer_checker timer_checker_inst (
  .CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .SFR_ADDR_I(SFR_ADDR_I), .SFR_WR_I(SFR_WR_I),
  .SFR_WDATA_I(SFR_WDATA_I), .TIMER_A_VECTOR_I(TIMER_A_VECTOR_I),
  .EXT_IRQ_A_VECTOR_I(EXT_IRQ_A_VECTOR_I), .EXT_IRQ_A_PIN_N_I(EXT_IRQ_A_PIN_N_I),
  .TIMER_A_OVERFLOW_FLAG_O(TIMER_A_OVERFLOW_FLAG_O), .EXT_IRQ_A_DETECT_O(EXT_IRQ_A_DETECT_O),
  .TIMER_A_OVERFLOW_PULSE_O(TIMER_A_OVERFLOW_PULSE_O),
  .TIMER_B_OVERFLOW_PULSE_O(TIMER_B_OVERFLOW_PULSE_O),
  .XDATA_STRETCH_CYCLES_O(XDATA_STRETCH_CYCLES_O));

// ==== tb/pin_partner.sv ====
// external pin model: count pins and interrupt pins
// assumes the bench requests edges and levels on the cpu clock
module pin_partner (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic count_en_i,
  input  wire logic irq_a_level_i,
  input  wire logic irq_b_level_i,
  output logic      count_a_o,
  output logic      count_b_o,
  output logic      irq_a_n_o,
  output logic      irq_b_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // square wave while enabled, idle high otherwise
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) count_a_o <= 1'b1;
    else count_a_o <= count_en_i ? !count_a_o : 1'b1;
  end
  assign count_b_o = count_a_o;
  // irq pins high means deasserted
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) {irq_b_n_o, irq_a_n_o} <= 2'b11;
    else {irq_b_n_o, irq_a_n_o} <= {irq_b_level_i, irq_a_level_i};
  end
endmodule // pin_partner

// ==== tb/dual_timer_ext_irq_ctrl_bench.sv ====
// self-checking bench for the dual timer block
// assumes the pin partner model and the bound checker
module dual_timer_ext_irq_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst_n, wr, va, vb, ia, ib, cen, la, lb;
  logic [7:0] addr, wdata, rdata, d;
  logic       fa, fb, da, db, pa, pb, rc;
  logic [3:0] st;
  wire logic  ca, cb, na, nb;
  int         fails, tests_run, gap;
  logic [7:0] tm [4] = '{8'h00, 8'h01, 8'h02, 8'h10};
  logic [7:0] ex [4] = '{8'h00, 8'h00, 8'h80, 8'h00};
  logic [7:0] gm [3] = '{8'h04, 8'h0c, 8'h0c};
  logic [7:0] ge [3] = '{8'h05, 8'h00, 8'h05};
  logic       gp [3] = '{1'b1, 1'b0, 1'b1};
  localparam logic [7:0] A_CTL  = timer_pkg::TIMER_IRQ_CONTROL_ADDR;
  localparam logic [7:0] A_MOD  = timer_pkg::TIMER_MODE_REG_ADDR;
  localparam logic [7:0] A_RATE = timer_pkg::TIMER_RATE_CONTROL_ADDR;
  dual_timer_ext_irq_ctrl dual_timer_ext_irq_ctrl_inst (
    .CLOCK_I(clk), .RESET_N_I(rst_n), .SFR_ADDR_I(addr), .SFR_WR_I(wr), .SFR_WDATA_I(wdata),
    .TIMER_A_VECTOR_I(va), .TIMER_B_VECTOR_I(vb), .EXT_IRQ_A_VECTOR_I(ia),
    .EXT_IRQ_B_VECTOR_I(ib), .EXT_IRQ_A_PIN_N_I(na), .EXT_IRQ_B_PIN_N_I(nb),
    .TIMER_A_COUNT_PIN_I(ca), .TIMER_B_COUNT_PIN_I(cb), .SFR_RDATA_O(rdata),
    .TIMER_A_OVERFLOW_FLAG_O(fa), .TIMER_B_OVERFLOW_FLAG_O(fb), .EXT_IRQ_A_DETECT_O(da),
    .EXT_IRQ_B_DETECT_O(db), .TIMER_A_OVERFLOW_PULSE_O(pa), .TIMER_B_OVERFLOW_PULSE_O(pb),
    .TIMER_C_RATE_SELECT_O(rc), .XDATA_STRETCH_CYCLES_O(st));
  pin_partner pin_partner_inst (.clk_i(clk), .rst_n_i(rst_n), .count_en_i(cen),
    .irq_a_level_i(la), .irq_b_level_i(lb), .count_a_o(ca), .count_b_o(cb),
    .irq_a_n_o(na), .irq_b_n_o(nb));
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    #1 v = rdata;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic vector(input logic [3:0] sel);
    @(posedge clk);
    {ib, ia, vb, va} <= sel;
    @(posedge clk);
    {ib, ia, vb, va} <= 4'h0;
    #1;
  endtask
  task automatic wait_pulse(input logic sel);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 64 && !seen; i++) begin
      @(posedge clk);
      #1 seen = sel ? pb : pa;
    end
    chk("overflow pulse", 8'h01, {7'h00, seen});
  endtask
  task automatic give_verdict();
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict();
  end
  initial begin
    {rst_n, wr, va, vb, ia, ib, cen} = 7'h00;
    {la, lb, addr, wdata} = {2'b11, 16'h0000};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(A_CTL, d);
    chk("irq control reset", 8'h00, d);
    rd_reg(A_RATE, d);
    chk("rate control reset", 8'h01, d);
    chk("stretch reset", 8'h03, {4'h0, st});
    wr_reg(A_RATE, 8'hff);
    rd_reg(A_RATE, d);
    chk("rate control rw", 8'h3f, d);
    chk("stretch max", 8'h09, {4'h0, st});
    chk("rate c", 8'h01, {7'h00, rc});
    wr_reg(A_RATE, 8'h18);
    chk("stretch min", 8'h02, {4'h0, st});
    for (int i = 0; i < 4; i++) begin
      logic s;
      s = (i == 3);
      wr_reg(A_MOD, tm[i]);
      wr_reg(timer_pkg::TL_A_ADDR + {7'h00, s}, 8'hff);
      wr_reg(timer_pkg::TH_A_ADDR + {7'h00, s}, (ex[i] == 8'h00) ? 8'hff : ex[i]);
      wr_reg(A_CTL, s ? 8'h40 : 8'h10);
      wait_pulse(s);
      wr_reg(A_CTL, s ? 8'h80 : 8'h20);
      chk("flag set", 8'h01, {7'h00, s ? fb : fa});
      vector(s ? 4'h2 : 4'h1);
      chk("flag clear", 8'h00, {7'h00, s ? fb : fa});
      rd_reg(timer_pkg::TL_A_ADDR + {7'h00, s}, d);
      chk("low byte", ex[i], (i == 0) ? (d & 8'h1f) : d);
      rd_reg(timer_pkg::TH_A_ADDR + {7'h00, s}, d);
      chk("high byte", ex[i], d);
      repeat (16) @(posedge clk);
      rd_reg(timer_pkg::TH_A_ADDR + {7'h00, s}, d);
      chk("held count", ex[i], d);
    end
    wr_reg(A_MOD, 8'h02);
    wr_reg(timer_pkg::TH_A_ADDR, 8'hff);
    wr_reg(timer_pkg::TL_A_ADDR, 8'hff);
    for (int i = 0; i < 2; i++) begin
      wr_reg(A_RATE, (i == 0) ? 8'h01 : 8'h18);
      wr_reg(A_CTL, 8'h10);
      wait_pulse(1'b0);
      gap = 0;
      do begin
        @(posedge clk);
        #1 gap++;
      end while (!pa && gap < 40);
      chk("tick gap", 8'((i == 0) ? timer_pkg::SLOW_DIV : timer_pkg::FAST_DIV), gap[7:0]);
      wr_reg(A_CTL, 8'h00);
    end
    for (int i = 0; i < 3; i++) begin
      wr_reg(A_MOD, gm[i]);
      wr_reg(timer_pkg::TL_A_ADDR, 8'h00);
      la <= gp[i];
      wr_reg(A_CTL, 8'h10);
      @(posedge clk);
      cen <= 1'b1;
      repeat (10) @(posedge clk);
      cen <= 1'b0;
      repeat (4) @(posedge clk);
      wr_reg(A_CTL, 8'h00);
      rd_reg(timer_pkg::TL_A_ADDR, d);
      chk("event count", ge[i], d);
    end
    la <= 1'b1;
    repeat (3) @(posedge clk);
    la <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("level low", 8'h01, {7'h00, da});
    wr_reg(A_CTL, 8'h00);
    #1 chk("level write", 8'h01, {7'h00, da});
    la <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("level high", 8'h00, {7'h00, da});
    wr_reg(A_CTL, 8'h01);
    la <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("edge set", 8'h01, {7'h00, da});
    vector(4'h4);
    chk("edge vector", 8'h00, {7'h00, da});
    @(posedge clk);
    la <= 1'b1;
    repeat (2) @(posedge clk);
    la <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("edge again", 8'h01, {7'h00, da});
    wr_reg(A_CTL, 8'h01);
    #1 chk("edge sw clear", 8'h00, {7'h00, da});
    rd_reg(A_CTL, d);
    chk("irq control edge", 8'h01, d);
    lb <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("level low b", 8'h01, {7'h00, db});
    lb <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("level high b", 8'h00, {7'h00, db});
    give_verdict();
  end
endmodule // dual_timer_ext_irq_ctrl_bench
